// *** tb/serial_host_model.sv ***
// Host model driving the three-wire serial register port
`timescale 1ns/1ps
`default_nettype none
module serial_host_model (
    input wire logic core_clk, // Clock
    input wire logic ser_data_out, // Device read data
    input wire logic ser_data_oe, // Device drive enable
    output logic ser_sel_n, // Frame select
    output logic ser_clk, // Bit clock
    output logic ser_data_in // Host data
);
    logic last_bit;
    // Undriven read line shows the inverse of its last level
    wire logic line_w = ser_data_oe ? ser_data_out : ~last_bit;
    initial begin
        ser_sel_n = 1'b1;
        ser_clk = 1'b0;
        ser_data_in = 1'b0;
        last_bit = 1'b0;
    end
    task automatic half();
        repeat (4) @(negedge core_clk);
    endtask : half
    task automatic xfer(input logic rd, input logic [4:0] a, input logic [31:0] wd,
        output logic [31:0] rdata);
        logic [31:0] w;
        logic [37:0] frame;
        w = wd;
        if (a == wake_regs_pkg::WAKE_CONTROL_ADDR) begin
            w = w & wake_regs_pkg::WAKE_CONTROL_WMASK;
            if (w[29]) w[28:24] = 5'h1f;
        end
        frame = {rd, a, w};
        rdata = 32'h0;
        @(negedge core_clk);
        ser_sel_n = 1'b0;
        for (int i = 37; i >= 0; i--) begin
            ser_data_in = frame[i];
            half();
            ser_clk = 1'b1;
            if (i < 32) begin
                rdata[i] = line_w;
                last_bit = line_w;
            end
            half();
            ser_clk = 1'b0;
        end
        half();
        ser_sel_n = 1'b1;
        ser_data_in = ~frame[0];
        half();
    endtask : xfer
endmodule : serial_host_model
`default_nettype wire

// *** tb/wake_slicer_regs_props.sv ***
// Checker for the slicer trim and wake-up control ports
`timescale 1ns/1ps
`default_nettype none
module wake_slicer_regs_props (
    input wire logic core_clk, // Clock
    input wire logic rst, // Reset
    input wire logic ser_sel_n, // Frame select
    input wire logic ser_data_oe, // Read drive
    input wire logic wake_message_valid, // Valid message
    input wire logic [3:0] slicer_reference_trim_field, // Trim code
    input wire logic discriminator_shift_up, // Up shift
    input wire logic discriminator_shift_down, // Down shift
    input wire logic wake_function_enable, // Enable
    input wire logic message_has_data, // Data field
    input wire logic length_by_stop_field, // Stop mode
    input wire logic [4:0] message_payload_length, // Length
    input wire logic message_has_address, // Address field
    input wire logic message_error_test, // Error test
    input wire logic stuffing_inhibit, // No stuffing
    input wire logic wake_period_strobe, // Period pulse
    input wire logic signal_strength_check, // First check
    input wire logic header_check // Second check
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    wire logic [5:0] trim_w = {slicer_reference_trim_field, discriminator_shift_up,
        discriminator_shift_down};
    wire logic [9:0] fmt_w = {message_has_data, length_by_stop_field, message_payload_length,
        message_has_address, message_error_test, stuffing_inhibit};
    sequence s_sel_idle;
        ser_sel_n [*3];
    endsequence
    sequence s_pulse_ends;
        !wake_period_strobe;
    endsequence
    a_trim_reset_val: assert property ($fell(rst) |-> trim_w == 6'h20)
        else $error("trim outputs wrong after reset");
    a_ctrl_reset_val: assert property ($fell(rst) |->
        {wake_function_enable, fmt_w} == 11'h3fc) else $error("control wrong after reset");
    a_enable_hw_clear: assert property (wake_message_valid |=> !wake_function_enable)
        else $error("enable not cleared by valid message");
    a_enable_rise_frame: assert property ($rose(wake_function_enable) |-> !ser_sel_n)
        else $error("enable set outside a frame");
    a_fields_in_frame: assert property ($changed({trim_w, fmt_w}) |-> !ser_sel_n)
        else $error("field changed outside a frame");
    a_oe_after_frame: assert property (s_sel_idle |-> !ser_data_oe)
        else $error("read drive left on after frame");
    a_oe_in_frame: assert property ($rose(ser_data_oe) |-> !ser_sel_n)
        else $error("read drive began outside frame");
    a_strength_enabled: assert property (signal_strength_check |->
        $past(wake_function_enable)) else $error("first check while disabled");
    a_header_enabled: assert property (header_check |-> $past(wake_function_enable))
        else $error("second check while disabled");
    a_period_pulse: assert property (wake_period_strobe |->
        $past(wake_function_enable) ##1 s_pulse_ends) else $error("bad period strobe");
endmodule : wake_slicer_regs_props
bind wake_slicer_regs wake_slicer_regs_props i_props (.core_clk(core_clk), .rst(rst),
    .ser_sel_n(ser_sel_n), .ser_data_oe(ser_data_oe), .wake_message_valid(wake_message_valid),
    .slicer_reference_trim_field(slicer_reference_trim_field),
    .discriminator_shift_up(discriminator_shift_up),
    .discriminator_shift_down(discriminator_shift_down),
    .wake_function_enable(wake_function_enable), .message_has_data(message_has_data),
    .length_by_stop_field(length_by_stop_field), .message_payload_length(message_payload_length),
    .message_has_address(message_has_address), .message_error_test(message_error_test),
    .stuffing_inhibit(stuffing_inhibit), .wake_period_strobe(wake_period_strobe),
    .signal_strength_check(signal_strength_check), .header_check(header_check));
`default_nettype wire

// *** tb/wake_slicer_regs_test.sv ***
// Testbench for the slicer trim and wake-up control registers
`timescale 1ns/1ps
`default_nettype none
module wake_slicer_regs_test;
    localparam int PTC = 20;
    localparam int CTC = 4;
    localparam logic [4:0] TRIM = wake_regs_pkg::SLICER_TRIM_ADDR;
    localparam logic [4:0] CTRL = wake_regs_pkg::WAKE_CONTROL_ADDR;
    logic core_clk, rst, msg_valid, osc_start;
    wire logic sel_n, sclk, sdi, sdo, soe, up, down, en, dat, stp, adr, err, stu;
    wire logic [3:0] trim;
    wire logic [4:0] len;
    wire logic [2:0] pulses;
    int failures, n_compared;
    wake_slicer_regs #(.PERIOD_TICK_CYCLES(PTC), .CHECK_TICK_CYCLES(CTC)) i_dut (
        .core_clk(core_clk), .rst(rst), .ser_sel_n(sel_n), .ser_clk(sclk),
        .ser_data_in(sdi), .ser_data_out(sdo), .ser_data_oe(soe),
        .wake_message_valid(msg_valid), .ref_osc_start(osc_start),
        .slicer_reference_trim_field(trim), .discriminator_shift_up(up),
        .discriminator_shift_down(down), .wake_function_enable(en), .message_has_data(dat),
        .length_by_stop_field(stp), .message_payload_length(len), .message_has_address(adr),
        .message_error_test(err), .stuffing_inhibit(stu), .wake_period_strobe(pulses[0]),
        .signal_strength_check(pulses[1]), .header_check(pulses[2]));
    serial_host_model i_host (.core_clk(core_clk), .ser_data_out(sdo), .ser_data_oe(soe),
        .ser_sel_n(sel_n), .ser_clk(sclk), .ser_data_in(sdi));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // ========================================================
    // Shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic conclude();
        if (failures == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude
    task automatic rd(input logic [4:0] a, output logic [31:0] d);
        i_host.xfer(1'b1, a, 32'h0, d);
    endtask : rd
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] unused;
        i_host.xfer(1'b0, a, d, unused);
    endtask : wr
    task automatic wait_hi(input int which, output time t);
        for (int k = 0; k < 20000; k++) begin
            @(negedge core_clk);
            if (pulses[which] === 1'b1) begin
                t = $time;
                return;
            end
        end
        failures++;
        $display("[FAIL] %0t wait timed out", $time);
        conclude();
    endtask : wait_hi
    // ========================================================
    // Scenarios
    task automatic t_reset();
        logic [31:0] d;
        rd(TRIM, d);
        check(d, 32'(wake_regs_pkg::SLICER_TRIM_RESET));
        rd(CTRL, d);
        check(d, wake_regs_pkg::WAKE_CONTROL_RESET);
    endtask : t_reset
    task automatic t_trim();
        logic [31:0] d;
        wr(TRIM, 32'hffffffd7);
        rd(TRIM, d);
        check({d[25:0], trim, up, down}, {20'h0, 6'h17, 6'h17});
        wr(TRIM, 32'h00000028);
        rd(TRIM, d);
        check({d[25:0], trim, up, down}, {20'h0, 6'h28, 6'h28});
    endtask : t_trim
    task automatic t_control();
        logic [31:0] d;
        wr(CTRL, 32'h15400004);
        rd(CTRL, d);
        check(d, 32'h15400004);
        check({22'h0, dat, stp, len, adr, err, stu}, 32'h000000ab);
        wr(5'h1f, 32'hffffffff);
        rd(5'h1f, d);
        check(d, 32'h0);
        rd(CTRL, d);
        check(d, 32'h15400004);
    endtask : t_control
    task automatic t_period();
        logic [8:0] code [5] = '{9'h001, 9'h081, 9'h101, 9'h181, 9'h07f};
        int ticks [5] = '{2, 17, 17, 257, 128};
        time t1, t2;
        for (int i = 0; i < 5; i++) begin
            wr(CTRL, 32'h0);
            wr(CTRL, 32'h80000000 | (32'(code[i]) << 13));
            wait_hi(0, t1);
            wait_hi(0, t2);
            check(32'((t2 - t1) / 10), 32'(ticks[i] * PTC));
        end
    endtask : t_period
    task automatic t_checks();
        int mult [8] = '{0, 1, 2, 3, 4, 8, 16, 31};
        time t0, t1, t2;
        int ms, m, n;
        for (int i = 0; i < 9; i++) begin
            ms = (i == 8) ? 16 : 2;
            m = (i == 8) ? 1 : mult[i];
            wr(CTRL, 32'h80000000 | ((i == 8) ? 32'h1008 : (32'h40 | 32'(i) << 3)));
            @(negedge core_clk);
            osc_start = 1'b1;
            t0 = $time;
            @(negedge core_clk);
            osc_start = 1'b0;
            wait_hi(1, t1);
            n = int'((t1 - t0) / 10) - ms * CTC;
            check(32'(n >= 0 && n <= 3), 32'h1);
            if (m == 0) begin
                check(32'(pulses[2]), 32'h1);
            end else begin
                wait_hi(2, t2);
                check(32'((t2 - t1) / 10), 32'(m * ms * CTC));
            end
        end
    endtask : t_checks
    task automatic t_clear();
        logic [31:0] d;
        wr(CTRL, 32'h80000000);
        rd(CTRL, d);
        check(d, 32'h80000000);
        msg_valid = 1'b1;
        @(negedge core_clk);
        msg_valid = 1'b0;
        @(negedge core_clk);
        check(32'(en), 32'h0);
        rd(CTRL, d);
        check(d, 32'h0);
        msg_valid = 1'b1;
        wr(CTRL, 32'h80000000);
        msg_valid = 1'b0;
        rd(CTRL, d);
        check(d, 32'h0);
        osc_start = 1'b1;
        @(negedge core_clk);
        osc_start = 1'b0;
        repeat (12) begin
            @(negedge core_clk);
            check(32'(pulses[1]), 32'h0);
        end
    endtask : t_clear
    initial begin
        rst = 1'b1;
        msg_valid = 1'b0;
        osc_start = 1'b0;
        failures = 0;
        n_compared = 0;
        repeat (3) @(negedge core_clk);
        rst = 1'b0;
        t_reset();
        t_trim();
        t_control();
        t_period();
        t_checks();
        t_clear();
        rst = 1'b1;
        repeat (2) @(negedge core_clk);
        rst = 1'b0;
        t_reset();
        conclude();
    end
endmodule : wake_slicer_regs_test
`default_nettype wire

// *** verilog/serial_reg_port.sv ***
// Three-wire serial slave turning host frames into register accesses
`timescale 1ns/1ps
`default_nettype none
module serial_reg_port (
    input wire logic core_clk, // System clock
    input wire logic rst, // Asynchronous reset
    input wire logic ser_sel_n, // Frame select, low during a frame
    input wire logic ser_clk, // Serial bit clock from host
    input wire logic ser_data_in, // Serial data from host
    output logic ser_data_out, // Serial read data
    output logic ser_data_oe, // Drive enable for read data
    output logic reg_wr, // Write pulse
    output logic [4:0] reg_addr, // Register address
    output logic [31:0] reg_wdata, // Write data
    input wire logic [31:0] reg_rdata // Read data for reg_addr
);
    logic clk_q_r;
    logic [5:0] bit_cnt_r;
    logic read_r;
    logic load_r;
    logic [31:0] shift_r;

    wire rise = ser_clk & ~clk_q_r & ~ser_sel_n;
    wire in_frame = (bit_cnt_r <= wake_regs_pkg::FRAME_LAST);
    wire take = rise & in_frame;
    wire addr_bit = take & (bit_cnt_r != 6'h00)
                    & (bit_cnt_r <= wake_regs_pkg::FRAME_ADDR_LAST);
    wire data_bit = take & (bit_cnt_r > wake_regs_pkg::FRAME_ADDR_LAST);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            clk_q_r <= 1'b0;
            bit_cnt_r <= 6'h00;
            read_r <= 1'b0;
            load_r <= 1'b0;
            shift_r <= 32'h00000000;
            reg_addr <= 5'h00;
            reg_wdata <= 32'h00000000;
            reg_wr <= 1'b0;
            ser_data_out <= 1'b0;
            ser_data_oe <= 1'b0;
        end else begin
            clk_q_r <= ser_clk;
            reg_wr <= 1'b0;
            load_r <= 1'b0;
            if (ser_sel_n) begin
                bit_cnt_r <= 6'h00;
                ser_data_oe <= 1'b0;
            end else begin
                if (take) begin
                    bit_cnt_r <= bit_cnt_r + 6'h01;
                end
                if (take && bit_cnt_r == 6'h00) begin
                    read_r <= ser_data_in;
                end
                if (addr_bit) begin
                    reg_addr <= {reg_addr[3:0], ser_data_in};
                    load_r <= (bit_cnt_r == wake_regs_pkg::FRAME_ADDR_LAST) & read_r;
                end
                if (load_r) begin
                    shift_r <= reg_rdata;
                    ser_data_out <= reg_rdata[31];
                    ser_data_oe <= 1'b1;
                end else if (data_bit && read_r) begin
                    shift_r <= {shift_r[30:0], 1'b0};
                    ser_data_out <= shift_r[30];
                end else if (data_bit) begin
                    shift_r <= {shift_r[30:0], ser_data_in};
                    if (bit_cnt_r == wake_regs_pkg::FRAME_LAST) begin
                        reg_wdata <= {shift_r[30:0], ser_data_in};
                        reg_wr <= 1'b1;
                    end
                end
            end
        end
    end
endmodule : serial_reg_port
`default_nettype wire

// *** verilog/tick_divider.sv ***
// Free-running divider giving a one-cycle tick every DIVIDE clocks
`timescale 1ns/1ps
`default_nettype none
module tick_divider #(
    parameter int unsigned DIVIDE = 16
) (
    input wire logic core_clk, // System clock
    input wire logic rst, // Asynchronous reset
    input wire logic clear, // Restart the division
    output logic tick // One-cycle tick
);
    localparam int CW = (DIVIDE > 1) ? $clog2(DIVIDE) : 1;
    localparam logic [CW-1:0] LAST = CW'(DIVIDE - 1);

    logic [CW-1:0] count_r;
    wire at_last = (count_r == LAST);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            count_r <= '0;
            tick <= 1'b0;
        end else if (clear) begin
            count_r <= '0;
            tick <= 1'b0;
        end else begin
            count_r <= at_last ? '0 : count_r + 1'b1;
            tick <= at_last;
        end
    end
endmodule : tick_divider
`default_nettype wire

// *** verilog/wake_regs_pkg.sv ***
// Constants shared by the slicer trim and wake-up control register block
`default_nettype none
package wake_regs_pkg;
    // =========================================================
    // Register addresses on the serial port
    localparam int ADDR_W = 5;
    localparam int DATA_W = 32;
    localparam logic [4:0] SLICER_TRIM_ADDR = 5'h0a;
    localparam logic [4:0] WAKE_CONTROL_ADDR = 5'h0b;
    // =========================================================
    // Reset values and writable bits
    localparam logic [5:0] SLICER_TRIM_RESET = 6'h20;
    localparam logic [31:0] WAKE_CONTROL_RESET = 32'h7f8be110;
    localparam logic [31:0] WAKE_CONTROL_WMASK = 32'hfffffffc;
    // =========================================================
    // Field positions
    localparam int TRIM_MSB = 5;
    localparam int TRIM_LSB = 2;
    localparam int SHIFT_UP_BIT = 1;
    localparam int SHIFT_DOWN_BIT = 0;
    localparam int ENABLE_BIT = 31;
    localparam int DATA_FIELD_BIT = 30;
    localparam int STOP_MODE_BIT = 29;
    localparam int LEN_MSB = 28;
    localparam int LEN_LSB = 24;
    localparam int ADDR_FIELD_BIT = 23;
    localparam int ERR_TEST_BIT = 22;
    localparam int PER_PRESC_MSB = 21;
    localparam int PER_PRESC_LSB = 20;
    localparam int PER_COUNT_MSB = 19;
    localparam int PER_COUNT_LSB = 13;
    localparam int WL1_PRESC_BIT = 12;
    localparam int WL1_COUNT_MSB = 11;
    localparam int WL1_COUNT_LSB = 6;
    localparam int WL2_MSB = 5;
    localparam int WL2_LSB = 3;
    localparam int STUFF_INHIBIT_BIT = 2;
    // =========================================================
    // Serial frame: one direction bit, address, data
    localparam logic [5:0] FRAME_ADDR_LAST = 6'h05;
    localparam logic [5:0] FRAME_LAST = 6'h25;
    // =========================================================
    // Timing
    localparam int CLK_FREQ_HZ = 100_000_000;
    localparam int PERIOD_TICK_MS = 10;
    localparam int CHECK_TICK_MS = 1;
    localparam int PERIOD_TICK_CYCLES = CLK_FREQ_HZ / 1000 * PERIOD_TICK_MS;
    localparam int CHECK_TICK_CYCLES = CLK_FREQ_HZ / 1000 * CHECK_TICK_MS;
endpackage : wake_regs_pkg
`default_nettype wire

// *** verilog/wake_slicer_regs.sv ***
// Slicer trim and wake-up control registers with wake timing engine
`timescale 1ns/1ps
`default_nettype none
module wake_slicer_regs #(
    parameter int unsigned PERIOD_TICK_CYCLES = wake_regs_pkg::PERIOD_TICK_CYCLES,
    parameter int unsigned CHECK_TICK_CYCLES = wake_regs_pkg::CHECK_TICK_CYCLES
) (
    input wire logic core_clk, // System clock, 100 MHz
    input wire logic rst, // Asynchronous reset, high
    // =========================================================
    // Three-wire serial register port
    input wire logic ser_sel_n, // Frame select, low active
    input wire logic ser_clk, // Serial bit clock
    input wire logic ser_data_in, // Serial data in
    output logic ser_data_out, // Serial data out
    output logic ser_data_oe, // Serial data drive enable
    // =========================================================
    // Events from the wake-up receiver
    input wire logic wake_message_valid, // Valid message received
    input wire logic ref_osc_start, // Reference oscillator started
    // =========================================================
    // Slicer controls
    output logic [3:0] slicer_reference_trim_field, // Slicer reference code
    output logic discriminator_shift_up, // Raise discriminator level
    output logic discriminator_shift_down, // Lower discriminator level
    // =========================================================
    // Wake message format controls
    output logic wake_function_enable, // Wake-up enabled
    output logic message_has_data, // Message carries data field
    output logic length_by_stop_field, // Length given by stop field
    output logic [4:0] message_payload_length, // Data bits minus one
    output logic message_has_address, // Message carries address field
    output logic message_error_test, // Error detection debug mode
    output logic stuffing_inhibit, // No bit stuffing
    // =========================================================
    // Wake timing events
    output logic wake_period_strobe, // Wake period elapsed
    output logic signal_strength_check, // Time for signal-strength check
    output logic header_check // Time for header detection check
);
    // =========================================================
    // Register storage
    logic [5:0] trim_r;
    logic [31:0] wake_r;
    logic [31:0] wake_nxt;

    logic reg_wr;
    logic [4:0] reg_addr;
    logic [31:0] reg_wdata;
    logic [31:0] reg_rdata;

    serial_reg_port u_port (
        .core_clk(core_clk),
        .rst(rst),
        .ser_sel_n(ser_sel_n),
        .ser_clk(ser_clk),
        .ser_data_in(ser_data_in),
        .ser_data_out(ser_data_out),
        .ser_data_oe(ser_data_oe),
        .reg_wr(reg_wr),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata)
    );

    // =========================================================
    // Address decode and read mux
    wire sel_trim = (reg_addr == wake_regs_pkg::SLICER_TRIM_ADDR);
    wire sel_wake = (reg_addr == wake_regs_pkg::WAKE_CONTROL_ADDR);
    wire trim_wr = reg_wr & sel_trim;
    wire wake_wr = reg_wr & sel_wake;

    // Unmapped addresses read as zero, narrow register zero-extended
    assign reg_rdata = sel_trim ? {26'h0, trim_r} :
                       sel_wake ? wake_r :
                       32'h00000000;

    // =========================================================
    // Wake control next value
    always_comb begin
        wake_nxt = wake_r;
        if (wake_wr) begin
            // Reserved low bits are never stored, so they read zero
            wake_nxt = reg_wdata & wake_regs_pkg::WAKE_CONTROL_WMASK;
        end
        if (wake_message_valid) begin
            wake_nxt[wake_regs_pkg::ENABLE_BIT] = 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            trim_r <= wake_regs_pkg::SLICER_TRIM_RESET;
            wake_r <= wake_regs_pkg::WAKE_CONTROL_RESET;
        end else begin
            if (trim_wr) begin
                trim_r <= reg_wdata[5:0];
            end
            wake_r <= wake_nxt;
        end
    end

    // =========================================================
    // Field outputs, straight from the register bits
    always_comb begin
        slicer_reference_trim_field =
            trim_r[wake_regs_pkg::TRIM_MSB:wake_regs_pkg::TRIM_LSB];
        discriminator_shift_up = trim_r[wake_regs_pkg::SHIFT_UP_BIT];
        discriminator_shift_down = trim_r[wake_regs_pkg::SHIFT_DOWN_BIT];
        wake_function_enable = wake_r[wake_regs_pkg::ENABLE_BIT];
        message_has_data = wake_r[wake_regs_pkg::DATA_FIELD_BIT];
        length_by_stop_field = wake_r[wake_regs_pkg::STOP_MODE_BIT];
        message_payload_length =
            wake_r[wake_regs_pkg::LEN_MSB:wake_regs_pkg::LEN_LSB];
        message_has_address = wake_r[wake_regs_pkg::ADDR_FIELD_BIT];
        message_error_test = wake_r[wake_regs_pkg::ERR_TEST_BIT];
        stuffing_inhibit = wake_r[wake_regs_pkg::STUFF_INHIBIT_BIT];
    end

    // =========================================================
    // Wake period target, in 10 ms ticks
    wire [1:0] per_presc =
        wake_r[wake_regs_pkg::PER_PRESC_MSB:wake_regs_pkg::PER_PRESC_LSB];
    wire [6:0] per_count =
        wake_r[wake_regs_pkg::PER_COUNT_MSB:wake_regs_pkg::PER_COUNT_LSB];
    wire [14:0] per_scaled;
    wire [14:0] per_target;

    // Codes 01 and 10 both mean two divide-by-16 stages bypassed to one
    assign per_scaled = (per_presc == 2'b11) ? {per_count, 8'h00} :
                        (per_presc != 2'b00) ? {4'h0, per_count, 4'h0} :
                        {8'h00, per_count};
    assign per_target = per_scaled + 15'h0001;

    // =========================================================
    // Wake period timer
    logic period_tick;
    logic [14:0] per_cnt_r;
    wire per_run = wake_r[wake_regs_pkg::ENABLE_BIT];
    wire [14:0] per_cnt_inc = per_cnt_r + 15'h0001;
    wire per_done = period_tick & (per_cnt_inc == per_target);

    tick_divider #(
        .DIVIDE(PERIOD_TICK_CYCLES)
    ) u_period_tick (
        .core_clk(core_clk),
        .rst(rst),
        .clear(~per_run),
        .tick(period_tick)
    );

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            per_cnt_r <= 15'h0000;
            wake_period_strobe <= 1'b0;
        end else if (!per_run) begin
            per_cnt_r <= 15'h0000;
            wake_period_strobe <= 1'b0;
        end else begin
            if (period_tick) begin
                per_cnt_r <= per_done ? 15'h0000 : per_cnt_inc;
            end
            wake_period_strobe <= per_done;
        end
    end

    // =========================================================
    // Check delays, in 1 ms ticks
    wire wl1_presc = wake_r[wake_regs_pkg::WL1_PRESC_BIT];
    wire [5:0] wl1_count =
        wake_r[wake_regs_pkg::WL1_COUNT_MSB:wake_regs_pkg::WL1_COUNT_LSB];
    wire [2:0] wl2_code = wake_r[wake_regs_pkg::WL2_MSB:wake_regs_pkg::WL2_LSB];
    wire [10:0] wl1_base = {5'h00, wl1_count} + 11'h001;
    wire [10:0] wl1_ms;
    wire [4:0] wl2_mult;
    wire [15:0] wl2_ms;

    assign wl1_ms = wl1_presc ? {wl1_base[6:0], 4'h0} : wl1_base;

    assign wl2_mult = (wl2_code == 3'h7) ? 5'h1f :
                      (wl2_code == 3'h6) ? 5'h10 :
                      (wl2_code == 3'h5) ? 5'h08 :
                      {2'h0, wl2_code};
    assign wl2_ms = {5'h00, wl1_ms} * {11'h000, wl2_mult};

    // =========================================================
    // Check sequencer, started by the reference oscillator
    typedef enum logic [1:0] {
        CHK_IDLE,
        CHK_RSSI,
        CHK_HEADER
    } check_state_e;

    check_state_e chk_r;
    check_state_e chk_nxt;
    logic [15:0] ms_cnt_r;
    logic [15:0] ms_cnt_nxt;
    logic rssi_go_nxt;
    logic header_go_nxt;
    logic check_tick;

    wire chk_start = ref_osc_start & per_run;
    wire [15:0] ms_inc = ms_cnt_r + 16'h0001;

    tick_divider #(
        .DIVIDE(CHECK_TICK_CYCLES)
    ) u_check_tick (
        .core_clk(core_clk),
        .rst(rst),
        .clear(chk_start),
        .tick(check_tick)
    );

    always_comb begin
        chk_nxt = chk_r;
        ms_cnt_nxt = ms_cnt_r;
        rssi_go_nxt = 1'b0;
        header_go_nxt = 1'b0;
        case (chk_r)
            CHK_IDLE: begin
                ms_cnt_nxt = 16'h0000;
            end
            CHK_RSSI: begin
                if (check_tick) begin
                    ms_cnt_nxt = ms_inc;
                    if (ms_inc == {5'h00, wl1_ms}) begin
                        rssi_go_nxt = 1'b1;
                        ms_cnt_nxt = 16'h0000;
                        if (wl2_mult == 5'h00) begin
                            header_go_nxt = 1'b1;
                            chk_nxt = CHK_IDLE;
                        end else begin
                            chk_nxt = CHK_HEADER;
                        end
                    end
                end
            end
            CHK_HEADER: begin
                if (check_tick) begin
                    ms_cnt_nxt = ms_inc;
                    if (ms_inc == wl2_ms) begin
                        header_go_nxt = 1'b1;
                        chk_nxt = CHK_IDLE;
                    end
                end
            end
            default: begin
                chk_nxt = CHK_IDLE;
            end
        endcase
        // A fresh oscillator start restarts timing; disable aborts it
        if (chk_start) begin
            chk_nxt = CHK_RSSI;
            ms_cnt_nxt = 16'h0000;
            rssi_go_nxt = 1'b0;
            header_go_nxt = 1'b0;
        end else if (!per_run) begin
            chk_nxt = CHK_IDLE;
            ms_cnt_nxt = 16'h0000;
            rssi_go_nxt = 1'b0;
            header_go_nxt = 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            chk_r <= CHK_IDLE;
            ms_cnt_r <= 16'h0000;
            signal_strength_check <= 1'b0;
            header_check <= 1'b0;
        end else begin
            chk_r <= chk_nxt;
            ms_cnt_r <= ms_cnt_nxt;
            signal_strength_check <= rssi_go_nxt;
            header_check <= header_go_nxt;
        end
    end
endmodule : wake_slicer_regs
`default_nettype wire
